/* design/rlt_defs.vh */
// Constants for the read decoder and latency code table
`ifndef RLT_DEFS_VH
`define RLT_DEFS_VH

// Read opcodes, 3-byte and 4-byte address forms
`define RLT_OP_READ3      8'h03
`define RLT_OP_READ4      8'h13
`define RLT_OP_FAST3      8'h0b
`define RLT_OP_FAST4      8'h0c
`define RLT_OP_DOUT3      8'h3b
`define RLT_OP_DOUT4      8'h3c
`define RLT_OP_QOUT3      8'h6b
`define RLT_OP_QOUT4      8'h6c
`define RLT_OP_DIO3       8'hbb
`define RLT_OP_DIO4       8'hbc
`define RLT_OP_QIO3       8'heb
`define RLT_OP_QIO4       8'hec
`define RLT_OP_DDR_FAST3  8'h0d
`define RLT_OP_DDR_FAST4  8'h0e
`define RLT_OP_DDR_DIO3   8'hbd
`define RLT_OP_DDR_DIO4   8'hbe
`define RLT_OP_DDR_QIO3   8'hed
`define RLT_OP_DDR_QIO4   8'hee

// Command classes
`define RLT_CLS_READ      4'h0
`define RLT_CLS_FAST      4'h1
`define RLT_CLS_DOUT      4'h2
`define RLT_CLS_QOUT      4'h3
`define RLT_CLS_DIO       4'h4
`define RLT_CLS_QIO       4'h5
`define RLT_CLS_DDR_FAST  4'h6
`define RLT_CLS_DDR_DIO   4'h7
`define RLT_CLS_DDR_QIO   4'h8
`define RLT_CLS_NONE      4'hf

// Latency codes
`define RLT_LC_00         2'b00
`define RLT_LC_01         2'b01
`define RLT_LC_10         2'b10
`define RLT_LC_11         2'b11

// Query parameter layout
`define RLT_PARAM_ID      8'h90
`define RLT_PARAM_LEN     8'h56
`define RLT_ROW_COUNT     8'h06
`define RLT_ROW_LEN       8'h0e
`define RLT_HDR_FREQ      8'h46
`define RLT_HDR_CODE      8'h43
`define RLT_TBL_BYTES     88
`define RLT_TBL_FILL      8'h00
`define RLT_NOT_SUPP      8'hff
`define RLT_ROW2_BASE     7'h12
`define RLT_ROW3_BASE     7'h20
`define RLT_ROW4_BASE     7'h2e
`define RLT_ROW5_BASE     7'h3c
`define RLT_ROW6_BASE     7'h4a
`define RLT_ROW_CELLS     7'h02

// Double-rate rows: fast mode/lat, dual I/O mode/lat, quad I/O mode/lat
`define RLT_DDR_ROW_LC11  48'h00_04_00_04_01_03
`define RLT_DDR_ROW_LC00  48'h00_05_00_06_01_06
`define RLT_DDR_ROW_LC01  48'h00_06_00_07_01_07
`define RLT_DDR_ROW_LC10  48'h00_07_00_08_01_08

`endif

/* design/rlt_table_rom.v */
// Latency code query table, three combinational read ports
`timescale 1ns/100ps
`default_nettype none
`include "rlt_defs.vh"

module rlt_table_rom (
    // Byte addresses, port 0 in the low bits
    input  wire [20:0] addr_flat,
    // Byte data, port 0 in the low bits
    output wire [23:0] data_flat
);

    ////////////////////////////////////////////////////////////////////////
    // Header then six rows of fourteen bytes, first byte leftmost
    localparam [8*`RLT_TBL_BYTES-1:0] TBL = {
        `RLT_PARAM_ID, `RLT_PARAM_LEN, `RLT_ROW_COUNT, `RLT_ROW_LEN,
        `RLT_HDR_FREQ, `RLT_HDR_CODE,
        `RLT_OP_READ3, `RLT_OP_READ4, `RLT_OP_FAST3, `RLT_OP_FAST4,
        `RLT_OP_DOUT3, `RLT_OP_DOUT4, `RLT_OP_QOUT3, `RLT_OP_QOUT4,
        `RLT_OP_DIO3, `RLT_OP_DIO4, `RLT_OP_QIO3, `RLT_OP_QIO4,
        112'h32_03_00_00_00_00_00_00_00_00_04_00_02_01,
        112'h50_00_ff_ff_00_08_00_08_00_08_04_00_02_04,
        112'h5a_01_ff_ff_00_08_00_08_00_08_04_01_02_04,
        112'h68_02_ff_ff_00_08_00_08_00_08_04_02_02_05,
        112'h85_02_ff_ff_00_08_ff_ff_ff_ff_ff_ff_ff_ff
    };

    ////////////////////////////////////////////////////////////////////////
    genvar p;
    generate
        for (p = 0; p < 3; p = p + 1) begin : g_port
            wire [6:0] a;
            assign a = addr_flat[7*p +: 7];
            // Beyond the parameter the bytes read as fill
            assign data_flat[8*p +: 8] = (a < 7'd88) ?
                TBL[8*(`RLT_TBL_BYTES-1-a) +: 8] : `RLT_TBL_FILL;
        end
    endgenerate

endmodule
`default_nettype wire

/* design/rlt_read_decoder.v */
// Read command decoder with latency selection and query table port
`timescale 1ns/100ps
`default_nettype none
`include "rlt_defs.vh"

module rlt_read_decoder (
    // Clock, reset, enable
    input  wire        ref_clk,
    input  wire        rst_b,
    input  wire        clk_en,
    // Serial link pins
    input  wire        sck,
    input  wire        cs_b,
    input  wire        si,
    // Latency configuration
    input  wire [1:0]  lat_code,
    input  wire        sck_above_104,
    // Decoded command
    output reg         cmd_valid_q,
    output reg  [3:0]  cmd_class_q,
    output reg         cmd_addr4_q,
    output reg         cmd_ddr_q,
    output reg         cmd_unknown_q,
    output reg         cmd_unsupported_q,
    output reg  [7:0]  mode_cycles_q,
    output reg  [7:0]  latency_cycles_q,
    // Query table read port
    input  wire [6:0]  tbl_addr,
    output reg  [7:0]  tbl_data_q
);

    ////////////////////////////////////////////////////////////////////////
    localparam [3:0] ST_IDLE  = 4'b0001;
    localparam [3:0] ST_SHIFT = 4'b0010;
    localparam [3:0] ST_LOOK  = 4'b0100;
    localparam [3:0] ST_HOLD  = 4'b1000;

    reg  [2:0]  pin_s1_q;
    reg  [2:0]  pin_s2_q;
    reg         sck_prev_q;
    reg  [3:0]  state_q;
    reg  [2:0]  bit_cnt_q;
    reg  [7:0]  op_q;

    wire        sck_rise;
    wire        cs_active;
    wire        si_s;
    reg  [3:0]  dec_class;
    reg         dec_addr4;
    reg  [6:0]  row_base;
    reg  [47:0] ddr_row;
    reg  [15:0] ddr_pair;
    reg  [7:0]  sel_mode;
    reg  [7:0]  sel_lat;
    wire [6:0]  cell_addr;
    wire [23:0] rom_data;

    ////////////////////////////////////////////////////////////////////////
    // Pins cross into ref_clk through two flops; SCK must stay well below
    // half of ref_clk for edge detection to see every rising edge
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_s1_q   <= 3'h7;
            pin_s2_q   <= 3'h7;
            sck_prev_q <= 1'b1;
        end else if (clk_en) begin
            pin_s1_q   <= {sck, cs_b, si};
            pin_s2_q   <= pin_s1_q;
            sck_prev_q <= pin_s2_q[2];
        end
    end

    assign sck_rise  = pin_s2_q[2] & ~sck_prev_q;
    assign cs_active = ~pin_s2_q[1];
    assign si_s      = pin_s2_q[0];

    ////////////////////////////////////////////////////////////////////////
    // Opcode decode
    always @* begin
        dec_class = `RLT_CLS_NONE;
        dec_addr4 = 1'b0;
        case (op_q)
            `RLT_OP_READ3:     dec_class = `RLT_CLS_READ;
            `RLT_OP_READ4: begin
                dec_class = `RLT_CLS_READ;
                dec_addr4 = 1'b1;
            end
            `RLT_OP_FAST3:     dec_class = `RLT_CLS_FAST;
            `RLT_OP_FAST4: begin
                dec_class = `RLT_CLS_FAST;
                dec_addr4 = 1'b1;
            end
            `RLT_OP_DOUT3:     dec_class = `RLT_CLS_DOUT;
            `RLT_OP_DOUT4: begin
                dec_class = `RLT_CLS_DOUT;
                dec_addr4 = 1'b1;
            end
            `RLT_OP_QOUT3:     dec_class = `RLT_CLS_QOUT;
            `RLT_OP_QOUT4: begin
                dec_class = `RLT_CLS_QOUT;
                dec_addr4 = 1'b1;
            end
            `RLT_OP_DIO3:      dec_class = `RLT_CLS_DIO;
            `RLT_OP_DIO4: begin
                dec_class = `RLT_CLS_DIO;
                dec_addr4 = 1'b1;
            end
            `RLT_OP_QIO3:      dec_class = `RLT_CLS_QIO;
            `RLT_OP_QIO4: begin
                dec_class = `RLT_CLS_QIO;
                dec_addr4 = 1'b1;
            end
            `RLT_OP_DDR_FAST3: dec_class = `RLT_CLS_DDR_FAST;
            `RLT_OP_DDR_FAST4: begin
                dec_class = `RLT_CLS_DDR_FAST;
                dec_addr4 = 1'b1;
            end
            `RLT_OP_DDR_DIO3:  dec_class = `RLT_CLS_DDR_DIO;
            `RLT_OP_DDR_DIO4: begin
                dec_class = `RLT_CLS_DDR_DIO;
                dec_addr4 = 1'b1;
            end
            `RLT_OP_DDR_QIO3:  dec_class = `RLT_CLS_DDR_QIO;
            `RLT_OP_DDR_QIO4: begin
                dec_class = `RLT_CLS_DDR_QIO;
                dec_addr4 = 1'b1;
            end
            default: begin
                dec_class = `RLT_CLS_NONE;
                dec_addr4 = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Single-rate row chosen by code; code 10b splits on clock rate
    always @* begin
        case (lat_code)
            `RLT_LC_11: row_base = `RLT_ROW2_BASE;
            `RLT_LC_00: row_base = `RLT_ROW3_BASE;
            `RLT_LC_01: row_base = `RLT_ROW4_BASE;
            default:    row_base = sck_above_104 ? `RLT_ROW6_BASE : `RLT_ROW5_BASE;
        endcase
    end

    // Mode cell of the class column, latency in the byte after it
    assign cell_addr = row_base + `RLT_ROW_CELLS + {dec_class[2:0], 1'b0};

    rlt_table_rom u_rom (
        .addr_flat ({tbl_addr, cell_addr + 7'd1, cell_addr}),
        .data_flat (rom_data)
    );

    // Double-rate row chosen by code alone
    always @* begin
        case (lat_code)
            `RLT_LC_11: ddr_row = `RLT_DDR_ROW_LC11;
            `RLT_LC_00: ddr_row = `RLT_DDR_ROW_LC00;
            `RLT_LC_01: ddr_row = `RLT_DDR_ROW_LC01;
            default:    ddr_row = `RLT_DDR_ROW_LC10;
        endcase
        case (dec_class)
            `RLT_CLS_DDR_FAST: ddr_pair = ddr_row[47:32];
            `RLT_CLS_DDR_DIO:  ddr_pair = ddr_row[31:16];
            default:           ddr_pair = ddr_row[15:0];
        endcase
        if (dec_class == `RLT_CLS_NONE) begin
            sel_mode = `RLT_NOT_SUPP;
            sel_lat  = `RLT_NOT_SUPP;
        end else if (dec_class >= `RLT_CLS_DDR_FAST) begin
            sel_mode = ddr_pair[15:8];
            sel_lat  = ddr_pair[7:0];
        end else begin
            sel_mode = rom_data[7:0];
            sel_lat  = rom_data[15:8];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Opcode shift and result registers
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q           <= ST_IDLE;
            bit_cnt_q         <= 3'h0;
            op_q              <= 8'h00;
            cmd_valid_q       <= 1'b0;
            cmd_class_q       <= `RLT_CLS_NONE;
            cmd_addr4_q       <= 1'b0;
            cmd_ddr_q         <= 1'b0;
            cmd_unknown_q     <= 1'b0;
            cmd_unsupported_q <= 1'b0;
            mode_cycles_q     <= 8'h00;
            latency_cycles_q  <= 8'h00;
            tbl_data_q        <= 8'h00;
        end else if (clk_en) begin
            cmd_valid_q <= 1'b0;
            tbl_data_q  <= rom_data[23:16];
            if (!cs_active) begin
                // Deselect aborts a partial opcode
                state_q   <= ST_IDLE;
                bit_cnt_q <= 3'h0;
            end else begin
                case (state_q)
                    ST_IDLE, ST_SHIFT: begin
                        state_q <= ST_SHIFT;
                        if (sck_rise) begin
                            op_q      <= {op_q[6:0], si_s};
                            bit_cnt_q <= bit_cnt_q + 3'h1;
                            if (bit_cnt_q == 3'h7) begin
                                state_q <= ST_LOOK;
                            end
                        end
                    end
                    ST_LOOK: begin
                        state_q           <= ST_HOLD;
                        cmd_valid_q       <= 1'b1;
                        cmd_class_q       <= dec_class;
                        cmd_addr4_q       <= dec_addr4;
                        cmd_ddr_q         <= (dec_class >= `RLT_CLS_DDR_FAST) &&
                                             (dec_class != `RLT_CLS_NONE);
                        cmd_unknown_q     <= (dec_class == `RLT_CLS_NONE);
                        cmd_unsupported_q <= (sel_mode == `RLT_NOT_SUPP);
                        mode_cycles_q     <= sel_mode;
                        latency_cycles_q  <= sel_lat;
                    end
                    ST_HOLD: begin
                        // Rest of the frame is address and data, not ours
                        state_q <= ST_HOLD;
                    end
                    default: begin
                        state_q <= ST_IDLE;
                    end
                endcase
            end
        end
    end

endmodule
`default_nettype wire

/* dv/rlt_read_decoder_asserts.sv */
// Concurrent checks on the read decoder ports
`timescale 1ns/100ps
`default_nettype none
module rlt_chk (
    // Clock and reset
    input wire logic       ref_clk,
    input wire logic       rst_b,
    // Configuration and table port
    input wire logic [1:0] lat_code,
    input wire logic [6:0] tbl_addr,
    input wire logic [7:0] tbl_data_q,
    // Decoded command
    input wire logic       cmd_valid_q,
    input wire logic [3:0] cmd_class_q,
    input wire logic       cmd_ddr_q,
    input wire logic       cmd_unknown_q,
    input wire logic [7:0] mode_cycles_q,
    input wire logic [7:0] latency_cycles_q
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    ////////////////////////////////////////////////////////////////////////////////
    a_valid_pulse: assert property (cmd_valid_q |=> !cmd_valid_q [*2])
        else $error("valid pulse too long");
    a_fields_hold: assert property (!cmd_valid_q |-> $stable({cmd_class_q, mode_cycles_q}))
        else $error("fields moved without a decode");
    a_unknown_ff: assert property (cmd_valid_q && cmd_unknown_q |-> cmd_class_q == 4'hf
        && mode_cycles_q == 8'hff && latency_cycles_q == 8'hff) else $error("unknown opcode");
    a_ddr_flag: assert property (cmd_valid_q |-> cmd_ddr_q == (cmd_class_q inside {[4'h6:4'h8]}))
        else $error("double-rate flag wrong");
    a_ddr_fast: assert property (cmd_valid_q && cmd_class_q == 4'h6 && $past(lat_code) == 2'b10
        |-> mode_cycles_q == 8'h00 && latency_cycles_q == 8'h07) else $error("ddr fast cycles");
    a_ddr_dual: assert property (cmd_valid_q && cmd_class_q == 4'h7 && $past(lat_code) == 2'b10
        |-> mode_cycles_q == 8'h00 && latency_cycles_q == 8'h08) else $error("ddr dual cycles");
    a_ddr_quad: assert property (cmd_valid_q && cmd_class_q == 4'h8 && $past(lat_code) == 2'b10
        |-> mode_cycles_q == 8'h01 && latency_cycles_q == 8'h08) else $error("ddr quad cycles");
    a_slow_zero: assert property (cmd_valid_q && $past(lat_code) == 2'b11 && cmd_class_q < 4'h3
        |-> mode_cycles_q == 8'h00 && latency_cycles_q == 8'h00) else $error("slow row cycles");
    a_tbl_id: assert property (tbl_addr == 7'h00 |=> tbl_data_q == 8'h90)
        else $error("table id byte");
    a_tbl_rows: assert property (tbl_addr == 7'h02 |=> tbl_data_q == 8'h06)
        else $error("table row count");
    a_tbl_marker: assert property (tbl_addr == 7'h04 |=> tbl_data_q == 8'h46)
        else $error("table header marker");
    a_tbl_tail: assert property (tbl_addr >= 7'h58 |=> tbl_data_q == 8'h00)
        else $error("byte past the parameter");
    c_ddr: cover property (cmd_valid_q && cmd_ddr_q);
    c_unknown: cover property (cmd_valid_q && cmd_unknown_q);
    c_unsupp: cover property (cmd_valid_q && !cmd_unknown_q && mode_cycles_q == 8'hff);
endmodule
`default_nettype wire

/* dv/rlt_host_model.sv */
// Serial host that clocks one read opcode per frame
`timescale 1ns/100ps
`default_nettype none
module rlt_host_model (
    // Link pins
    output var logic sck,
    output var logic cs_b,
    output var logic si
);
    initial begin
        sck = 1'b0;
        cs_b = 1'b1;
        si = 1'b0;
    end
    // 80 ns clock keeps every row's limit; nbits below 8 aborts the frame
    task automatic send(input logic [7:0] op, input int nbits);
        int i;
        cs_b = 1'b0;
        for (i = 7; i > 7 - nbits; i--) begin
            si = op[i];
            #40 sck = 1'b1;
            #40 sck = 1'b0;
        end
        // Released line must not keep the last bit
        si = ~si;
        #40 cs_b = 1'b1;
        #80;
    endtask
endmodule
`default_nettype wire

/* dv/tb_top.sv */
// Self-checking bench for the read decoder
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic             ref_clk = 1'b0;
    logic             rst_b = 1'b0;
    logic [1:0]       lat_code = 2'b00;
    logic             sck_above_104 = 1'b0;
    logic             clk_en = 1'b1;
    logic [6:0]       tbl_addr = 7'h00;
    logic             sck, cs_b, si, cmd_valid_q, cmd_addr4_q, cmd_ddr_q;
    logic             cmd_unknown_q, cmd_unsupported_q;
    logic [3:0]       cmd_class_q;
    logic [7:0]       mode_cycles_q, latency_cycles_q, tbl_data_q;
    logic [0:87][7:0] tbl = {144'h9056060e464303130b0c3b3c6b6cbbbcebec,
        112'h3203000000000000000004000201, 112'h5000ffff000800080008040002_04,
        112'h5a01ffff00080008000804010204, 112'h6802ffff00080008000804020205,
        112'h8502ffff0008ffffffffffffffff};
    logic [0:3][0:5][7:0] ddr = {48'h000500060106, 48'h000600070107, 48'h000700080108,
        48'h000400040103};
    logic [0:5][7:0]  dop = 48'h0d0ebdbeedee;
    logic [31:0]      seed = 32'h0000135a;
    int               n_mismatch = 0;
    int               checks = 0;
    int               n_valid = 0;

    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (cmd_valid_q === 1'b1) n_valid <= n_valid + 1;

    rlt_read_decoder rlt_read_decoder_i (.ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en),
        .sck(sck), .cs_b(cs_b), .si(si), .lat_code(lat_code), .sck_above_104(sck_above_104),
        .cmd_valid_q(cmd_valid_q), .cmd_class_q(cmd_class_q), .cmd_addr4_q(cmd_addr4_q),
        .cmd_ddr_q(cmd_ddr_q), .cmd_unknown_q(cmd_unknown_q),
        .cmd_unsupported_q(cmd_unsupported_q), .mode_cycles_q(mode_cycles_q),
        .latency_cycles_q(latency_cycles_q), .tbl_addr(tbl_addr), .tbl_data_q(tbl_data_q));
    rlt_host_model rlt_host_model_i (.sck(sck), .cs_b(cs_b), .si(si));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Class, addr4, ddr, unknown, mode, latency
    function automatic logic [22:0] expect_of(input logic [7:0] op, input logic [1:0] lc,
                                              input logic hi);
        int k;
        int b;
        b = (lc == 2'b11) ? 8'h12 : (lc == 2'b00) ? 8'h20 : (lc == 2'b01) ? 8'h2e :
            hi ? 8'h4a : 8'h3c;
        expect_of = {4'hf, 3'b001, 16'hffff};
        for (k = 0; k < 12; k++)
            if (tbl[6 + k] == op)
                expect_of = {4'(k / 2), k[0], 2'b00, tbl[b + 2 + k / 2 * 2], tbl[b + 3 + k / 2 * 2]};
        for (k = 0; k < 6; k++)
            if (dop[k] == op)
                expect_of = {4'(6 + k / 2), k[0], 2'b10, ddr[lc][k / 2 * 2], ddr[lc][k / 2 * 2 + 1]};
    endfunction

    task automatic check(input logic ok, input string msg);
        checks++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask

    task automatic final_report();
        if (n_mismatch == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic probe(input logic [6:0] a);
        @(posedge ref_clk);
        #1;
        tbl_addr = a;
        @(posedge ref_clk);
        #1;
        check(tbl_data_q === (a < 7'h58 ? tbl[a] : 8'h00), "table byte");
    endtask

    task automatic run(input logic [7:0] op, input logic [1:0] lc, input logic hi, input int nb);
        int v;
        int i;
        logic [22:0] e;
        @(posedge ref_clk);
        #1;
        lat_code = lc;
        sck_above_104 = hi;
        v = n_valid;
        e = expect_of(op, lc, hi);
        rlt_host_model_i.send(op, nb);
        for (i = 0; i < 30 && n_valid == v; i++)
            @(posedge ref_clk);
        #1;
        check(n_valid == v + (nb == 8), "result count");
        if (nb == 8) begin
            check({cmd_class_q, cmd_addr4_q, cmd_ddr_q, cmd_unknown_q, mode_cycles_q,
                   latency_cycles_q} === e, "decoded fields");
            check(cmd_unsupported_q === (e[15:8] == 8'hff), "unsupported flag");
        end
        if (i == 30 && nb == 8)
            final_report();
    endtask

    initial begin
        int c;
        int k;
        logic [31:0] r;
        repeat (2) @(posedge ref_clk);
        #1;
        check(cmd_class_q === 4'hf && cmd_valid_q === 1'b0, "reset state");
        rst_b = 1'b1;
        repeat (4) @(posedge ref_clk);
        for (k = 0; k < 128; k++)
            probe(k[6:0]);
        for (k = 0; k < 20; k++) begin
            r = rnd();
            probe(r[6:0]);
        end
        // Host walk to the next parameter must land just past the six rows
        probe(7'h01);
        check(tbl_data_q + 2 == 6 * 14 + 4, "next parameter position");
        // Enable low must freeze the table register against an address change
        clk_en = 1'b0;
        tbl_addr = 7'h05;
        repeat (3) @(posedge ref_clk);
        #1;
        check(tbl_data_q === 8'h56, "frozen by clock enable");
        clk_en = 1'b1;
        @(posedge ref_clk);
        #1;
        check(tbl_data_q === 8'h43, "enable released");
        for (c = 0; c < 8; c++)
            for (k = 0; k < 12; k++)
                run(tbl[6 + k], c[1:0], c[2], 8);
        for (c = 0; c < 4; c++)
            for (k = 0; k < 6; k++)
                run(dop[k], c[1:0], 1'b0, 8);
        for (k = 0; k < 30; k++) begin
            r = rnd();
            run(r[7:0], r[9:8], r[10], 8);
        end
        run(8'h0b, 2'b11, 1'b0, 4);
        run(8'h0b, 2'b11, 1'b0, 8);
        final_report();
    end
endmodule

bind rlt_read_decoder rlt_chk rlt_chk_i (.ref_clk(ref_clk), .rst_b(rst_b),
    .lat_code(lat_code), .tbl_addr(tbl_addr), .tbl_data_q(tbl_data_q),
    .cmd_valid_q(cmd_valid_q), .cmd_class_q(cmd_class_q), .cmd_ddr_q(cmd_ddr_q),
    .cmd_unknown_q(cmd_unknown_q), .mode_cycles_q(mode_cycles_q),
    .latency_cycles_q(latency_cycles_q));
`default_nettype wire
